// ===== hdl/wdt_block.sv
// Watchdog control register, time-out logic and vector selection.
// Assumes a core that reports vector execution and watchdog-reset instructions as pulses.
//
// Summary of operation
// R1 - Cause flag forces reset enable high
// R2 - Software clears cause flag before enable
// R3 - Four-bit select at bits 5,2..0
// R4 - Codes 0-9 give 2048 to 1048576 cycles
// R5 - Watchdog reset enters vector at 0x0000
// R6 - Time-out vector six at 0x000a/0x0005
// R7 - Unlock write then change within four
// R8 - Unlock bit self-clears after four cycles
// R9 - Time-out sets flag, vector or one clears
// R10 - Combined mode: vector clears enable and flag
// R11 - Counter restarts on instruction, compares selection
`timescale 1ns/10ps
`default_nettype none
module wdt_block
	import wdt_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic large_memory,
	input wire logic osc_tick,
	input wire logic wdr_instr,
	input wire logic vector_taken,
	input wire logic global_irq_en,
	output logic irq_request,
	output logic [15:0] vector_address,
	output logic system_reset,
	output logic irq
);
	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rst_a_q;
	logic rst_n;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rst_a_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_a_q <= 1'b1;
			rst_n <= rst_a_q;
		end
	end
	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic ack_q;
	logic [7:0] ctrl_q;
	logic cause_q;
	logic [1:0] status_q;
	logic [1:0] mask_q;
	logic [2:0] unlock_q;
	logic [15:0] vec_q;
	logic sysrst_q;
	wire logic access = (avs_read || avs_write) && !ack_q;
	wire logic wr = avs_write && ack_q;
	wire logic wr_ctrl = wr && (avs_address == ADDR_CONTROL);
	wire logic wr_cause = wr && (avs_address == ADDR_RESET_CAUSE);
	wire logic wr_stat = wr && (avs_address == ADDR_IRQ_STATUS);
	wire logic wr_mask = wr && (avs_address == ADDR_IRQ_MASK);
	wire logic [7:0] wd = avs_writedata[7:0];
	assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= access;
		end
	end
	logic [31:0] rd;
	always_comb begin
		if (avs_address == ADDR_CONTROL) begin
			rd = {24'h0, ctrl_q};
		end else if (avs_address == ADDR_RESET_CAUSE) begin
			rd = {28'h0, cause_q, 3'h0};
		end else if (avs_address == ADDR_IRQ_STATUS) begin
			rd = {30'h0, status_q};
		end else if (avs_address == ADDR_IRQ_MASK) begin
			rd = {30'h0, mask_q};
		end else begin
			rd = 32'h0;
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0;
		end else if (access && avs_read) begin
			avs_readdata <= rd;
		end
	end
	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	wire logic unlocked = ctrl_q[BIT_UNLOCK];
	wire logic open_req = wd[BIT_UNLOCK] && wd[BIT_RESET_ENABLE]; // R7
	wire logic [3:0] sel = {ctrl_q[BIT_SEL_MSB], ctrl_q[2:0]}; // R3
	wire logic wdt_enabled = ctrl_q[BIT_RESET_ENABLE] || ctrl_q[BIT_IRQ_ENABLE];
	wire logic timeout;
	wire logic wdt_vec = vector_taken && irq_request;
	wire logic reset_now = timeout && ctrl_q[BIT_RESET_ENABLE]
		&& !(ctrl_q[BIT_IRQ_ENABLE]);
	wire logic irq_event = timeout && ctrl_q[BIT_IRQ_ENABLE];
	logic [7:0] ctrl_d;
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl) begin
			ctrl_d[BIT_IRQ_ENABLE] = wd[BIT_IRQ_ENABLE];
			if (wd[BIT_IRQ_FLAG]) begin
				ctrl_d[BIT_IRQ_FLAG] = 1'b0; // R9
			end
			if (unlocked && !wd[BIT_UNLOCK]) begin
				ctrl_d[BIT_RESET_ENABLE] = wd[BIT_RESET_ENABLE]; // R7
				ctrl_d[BIT_SEL_MSB] = wd[BIT_SEL_MSB];
				ctrl_d[2:0] = wd[2:0];
				ctrl_d[BIT_UNLOCK] = 1'b0;
			end else if (open_req) begin
				ctrl_d[BIT_UNLOCK] = 1'b1;
				ctrl_d[BIT_RESET_ENABLE] = 1'b1;
			end else if (wd[BIT_RESET_ENABLE]) begin
				ctrl_d[BIT_RESET_ENABLE] = 1'b1;
			end
		end
		if (unlocked && unlock_q == 3'h1) begin
			ctrl_d[BIT_UNLOCK] = 1'b0; // R8
		end
		if (wdt_vec) begin
			ctrl_d[BIT_IRQ_FLAG] = 1'b0; // R9
			if (ctrl_q[BIT_RESET_ENABLE]) begin
				ctrl_d[BIT_IRQ_ENABLE] = 1'b0; // R10
			end
		end
		if (irq_event) begin
			ctrl_d[BIT_IRQ_FLAG] = 1'b1; // R9
		end
		if (cause_q) begin
			ctrl_d[BIT_RESET_ENABLE] = 1'b1; // R1 R2
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= CONTROL_RESET;
			unlock_q <= 3'h0;
		end else begin
			ctrl_q <= ctrl_d;
			unlock_q <= (ctrl_d[BIT_UNLOCK] && !unlocked) ? UNLOCK_CYCLES : // R8
				(unlock_q != 3'h0 ? 3'(unlock_q - 3'h1) : 3'h0);
		end
	end
	// The cause flag survives the watchdog's own reset pulse, set on time-out reset.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cause_q <= 1'b0;
		end else if (reset_now) begin
			cause_q <= 1'b1; // R1
		end else if (wr_cause && !wd[BIT_CAUSE_FLAG]) begin
			cause_q <= 1'b0; // R2
		end
	end
	// ------------------------------------------------------------
	// Counter, reset and vectors
	// ------------------------------------------------------------
	wdt_counter u_counter (
		.mclk(mclk),
		.rst_n(rst_n),
		.run(wdt_enabled),
		.tick(osc_tick),
		.restart(wdr_instr),
		.sel(sel),
		.timeout(timeout)
	);
	assign irq_request = ctrl_q[BIT_IRQ_FLAG] && ctrl_q[BIT_IRQ_ENABLE] && global_irq_en;
	assign system_reset = sysrst_q;
	assign vector_address = vec_q;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sysrst_q <= 1'b0;
			vec_q <= VEC_RESET;
		end else begin
			sysrst_q <= reset_now;
			if (reset_now) begin
				vec_q <= VEC_RESET; // R5
			end else if (irq_request) begin
				vec_q <= large_memory ? VEC_TIMEOUT_LARGE : VEC_TIMEOUT_SMALL; // R6
			end
		end
	end
	// ------------------------------------------------------------
	// Event status and interrupt
	// ------------------------------------------------------------
	wire logic [1:0] events = {reset_now, irq_event};
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			status_q <= 2'h0;
			mask_q <= 2'h0;
		end else begin
			status_q <= events | (status_q & ~(wr_stat ? wd[1:0] : 2'h0));
			if (wr_mask) begin
				mask_q <= wd[1:0];
			end
		end
	end
	assign irq = |(status_q & mask_q);
	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_cause_forces_enable: assert property (@(posedge mclk) disable iff (!rst_n) // R1
		cause_q |=> ctrl_q[BIT_RESET_ENABLE]) else $error("reset enable low under cause");
	sequence s_open;
		ctrl_q[BIT_UNLOCK] && !$past(ctrl_q[BIT_UNLOCK]);
	endsequence
	a_unlock_expires: assert property (@(posedge mclk) disable iff (!rst_n) // R8
		s_open |-> ##[1:4] !ctrl_q[BIT_UNLOCK]) else $error("unlock stayed open");
	a_locked_select: assert property (@(posedge mclk) disable iff (!rst_n) // R7
		!ctrl_q[BIT_UNLOCK] |=> $stable(sel)) else $error("select changed while locked");
	a_flag_on_timeout: assert property (@(posedge mclk) disable iff (!rst_n) // R9
		irq_event |=> ctrl_q[BIT_IRQ_FLAG]) else $error("flag not set");
	a_vector_clears: assert property (@(posedge mclk) disable iff (!rst_n) // R10
		(wdt_vec && ctrl_q[BIT_RESET_ENABLE] && !irq_event) |=>
		!ctrl_q[BIT_IRQ_ENABLE] && !ctrl_q[BIT_IRQ_FLAG]) else $error("vector no clear");
	a_reset_vector: assert property (@(posedge mclk) disable iff (!rst_n) // R5
		reset_now |=> system_reset && vector_address == VEC_RESET) else $error("bad reset");
	a_irq_vector: assert property (@(posedge mclk) disable iff (!rst_n) // R6
		(irq_request && !reset_now && large_memory) |=> vector_address == VEC_TIMEOUT_LARGE)
		else $error("bad time-out vector");
	a_restart_count: assert property (@(posedge mclk) disable iff (!rst_n) // R11
		wdr_instr |=> u_counter.count_q == 21'h0) else $error("counter not restarted");
	a_select_width: assert property (@(posedge mclk) disable iff (!rst_n) // R3 R4
		timeout |-> u_counter.count_q == 21'(u_counter.limit - 21'h1)) else $error("bad limit");
endmodule
`default_nettype wire

// ===== hdl/wdt_counter.sv
// Watchdog cycle counter on the watchdog-oscillator tick.
// Assumes the tick input is a one-cycle pulse in the system clock domain.
`timescale 1ns/10ps
`default_nettype none
module wdt_counter
	import wdt_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic tick,
	input wire logic restart,
	input wire logic [3:0] sel,
	output logic timeout
);
	logic [20:0] count_q;
	logic [20:0] limit;
	wire logic [3:0] sel_ok;
	assign sel_ok = (sel > SEL_MAX) ? SEL_MAX : sel; // R4
	assign limit = 21'(21'h1 << (BASE_SHIFT + int'(sel_ok))); // R4
	assign timeout = run && tick && (21'(count_q + 21'h1) >= limit); // R11
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= '0;
		end else if (restart || !run || timeout) begin
			count_q <= '0; // R11
		end else if (tick) begin
			count_q <= 21'(count_q + 21'h1);
		end
	end
endmodule
`default_nettype wire

// ===== hdl/wdt_pkg.sv
// Constants for the watchdog time-out and vector block.
// Assumes a single 20 MHz system clock and an Avalon-MM register port.
package wdt_pkg;
	// ------------------------------------------------------------
	// Register map (word aligned byte addresses)
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_RESET_CAUSE = 4'h4;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;
	// ------------------------------------------------------------
	// Control and reset-cause register fields
	// ------------------------------------------------------------
	localparam int BIT_IRQ_FLAG = 7;
	localparam int BIT_IRQ_ENABLE = 6;
	localparam int BIT_SEL_MSB = 5;
	localparam int BIT_UNLOCK = 4;
	localparam int BIT_RESET_ENABLE = 3;
	localparam int BIT_CAUSE_FLAG = 3;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	// ------------------------------------------------------------
	// Timing, vectors and event bits
	// ------------------------------------------------------------
	localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
	localparam logic [3:0] SEL_MAX = 4'h9;
	localparam int BASE_SHIFT = 11;
	localparam logic [15:0] VEC_RESET = 16'h0000;
	localparam logic [15:0] VEC_TIMEOUT_LARGE = 16'h000a;
	localparam logic [15:0] VEC_TIMEOUT_SMALL = 16'h0005;
	localparam int EVT_TIMEOUT = 0;
	localparam int EVT_SYSRESET = 1;
endpackage

// ===== test/watchdog_timeout_and_vectors_test.sv
// Self-checking bench for the watchdog control, time-out and vector block.
// Assumes wdt_pkg and wdt_block are compiled first; the bench drives every port itself.
`timescale 1ns/10ps
`default_nettype none
module watchdog_timeout_and_vectors_test
	import wdt_pkg::*;
;
	logic mclk, resetn, rd, wr, big, tick, wdr, vtk, gie;
	logic [3:0] adr;
	logic [31:0] wd, rdat, q;
	logic wait_b, irq_req, sys_rst, irq;
	logic [15:0] vec;
	int errors = 0;
	int n_tests = 0;
	int n;
	wdt_block i_dut (.mclk(mclk), .resetn(resetn), .avs_address(adr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wait_b),
		.large_memory(big), .osc_tick(tick), .wdr_instr(wdr), .vector_taken(vtk),
		.global_irq_en(gie), .irq_request(irq_req), .vector_address(vec),
		.system_reset(sys_rst), .irq(irq));
	// ----------------------------------------
	// Clock and oscillator ticks
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// Ticks come every other cycle, so one oscillator cycle is two clocks.
	always @(posedge mclk) begin
		tick <= ~tick & resetn;
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		k = 0;
		adr <= a;
		wd <= d;
		rd <= ~w;
		wr <= w;
		do begin
			@(posedge mclk);
			k++;
		end while (wait_b !== 1'b0 && k < 20);
		q = rdat;
		chk(32'(k < 20), 1);
		rd <= 1'b0;
		wr <= 1'b0;
		// One idle edge, so that a following call never re-raises a strobe in this time step.
		@(posedge mclk);
	endtask
	task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
		bus(1'b0, a, 0);
		chk(q, exp);
	endtask
	task automatic pulse(input int which);
		@(posedge mclk);
		if (which == 0) wdr <= 1'b1; else vtk <= 1'b1;
		@(posedge mclk);
		wdr <= 1'b0;
		vtk <= 1'b0;
	endtask
	// Counts clocks until a time-out shows as a reset pulse or an interrupt request.
	task automatic run_to(input int lo, input int hi);
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (sys_rst !== 1'b1 && irq_req !== 1'b1 && n < 20000);
		chk(32'(n >= lo && n <= hi), 1);
	endtask
	task automatic results;
		if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		rchk(ADDR_CONTROL, 32'h00);
		rchk(ADDR_RESET_CAUSE, 32'h00);
		bus(1'b1, 4'h2, 32'hff);
		rchk(4'h2, 32'h00);
		chk(irq, 1'b0);
	endtask
	task automatic t_sysreset;
		bus(1'b1, ADDR_CONTROL, 32'h08);
		pulse(0);
		repeat (3000) @(posedge mclk);
		pulse(0);
		run_to(4085, 4110);
		chk(sys_rst, 1'b1);
		repeat (2) @(posedge mclk);
		chk(vec, VEC_RESET);
		rchk(ADDR_RESET_CAUSE, 32'h08);
		bus(1'b1, ADDR_CONTROL, 32'h18);
		bus(1'b1, ADDR_CONTROL, 32'h00);
		rchk(ADDR_CONTROL, 32'h08);
		bus(1'b1, ADDR_RESET_CAUSE, 32'h00);
		bus(1'b1, ADDR_CONTROL, 32'h18);
		bus(1'b1, ADDR_CONTROL, 32'h00);
		rchk(ADDR_CONTROL, 32'h00);
		bus(1'b1, ADDR_IRQ_MASK, 32'h02);
		chk(irq, 1'b1);
		bus(1'b1, ADDR_IRQ_STATUS, 32'h03);
		chk(irq, 1'b0);
	endtask
	// A late second write must find the window shut and change nothing protected.
	task automatic t_late;
		bus(1'b1, ADDR_CONTROL, 32'h18);
		bus(1'b1, ADDR_CONTROL, 32'h00);
		bus(1'b1, ADDR_CONTROL, 32'h18);
		repeat (6) @(posedge mclk);
		rchk(ADDR_CONTROL, 32'h08);
		bus(1'b1, ADDR_CONTROL, 32'h01);
		rchk(ADDR_CONTROL, 32'h08);
	endtask
	task automatic t_irq;
		bus(1'b1, ADDR_CONTROL, 32'h18);
		bus(1'b1, ADDR_CONTROL, 32'h41);
		pulse(0);
		run_to(8180, 8210);
		chk(irq_req, 1'b1);
		repeat (2) @(posedge mclk);
		chk(vec, VEC_TIMEOUT_LARGE);
		rchk(ADDR_CONTROL, 32'hc1);
		gie <= 1'b0;
		@(posedge mclk);
		chk(irq_req, 1'b0);
		gie <= 1'b1;
		bus(1'b1, ADDR_IRQ_MASK, 32'h01);
		chk(irq, 1'b1);
		bus(1'b1, ADDR_CONTROL, 32'hc1);
		rchk(ADDR_CONTROL, 32'h41);
		big <= 1'b0;
		run_to(8000, 8210);
		repeat (2) @(posedge mclk);
		chk(vec, VEC_TIMEOUT_SMALL);
		pulse(1);
		rchk(ADDR_CONTROL, 32'h41);
	endtask
	task automatic t_combined;
		bus(1'b1, ADDR_CONTROL, 32'h18);
		bus(1'b1, ADDR_CONTROL, 32'h48);
		pulse(0);
		run_to(4085, 4110);
		chk(irq_req, 1'b1);
		pulse(1);
		rchk(ADDR_CONTROL, 32'h08);
		run_to(4000, 4110);
		chk(sys_rst, 1'b1);
		chk(vec, VEC_RESET);
		bus(1'b1, ADDR_RESET_CAUSE, 32'h00);
		bus(1'b1, ADDR_CONTROL, 32'h18);
		bus(1'b1, ADDR_CONTROL, 32'h20);
		rchk(ADDR_CONTROL, 32'h20);
	endtask
	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		{resetn, rd, wr, tick, wdr, vtk} = 6'h00;
		{big, gie} = 2'h3;
		adr = 4'h0;
		wd = 32'h0;
		repeat (4) @(posedge mclk);
		resetn <= 1'b1;
		repeat (3) @(posedge mclk);
		t_reset();
		t_sysreset();
		t_late();
		t_irq();
		t_combined();
		results();
	end
	initial begin
		#4000000;
		errors++;
		results();
	end
endmodule
`default_nettype wire
